/* pwm_timer_pkg.sv */
// Purpose: Constants for the 8-bit PWM down-counting timer.
// Assumes: Core bus is an 8-bit memory-mapped data space.
// Notes:   Register addresses follow the data space map.
// Operation
// R1: Run bit 4 starts and stops counting
// R2: Count decrements once per prescaled tick
// R3: Prescale field divides by 1, 2, 4, 8
// R4: Count 0x00 to next tick is underflow
// R5: Underflow reloads count from reload register
// R6: Underflow sets pending flag at bit 3
// R7: Toggle enable bit 5 inverts output on underflow
// R8: Output shares port pin two with port data
// R9: Interrupt needs enable bit and global enable
// R10: Interrupt requested when pending flag newly sets
// R11: Reset loads count 0xff, reload 0x00
// R12: Interrupts coincide with both output edges
// R13: Software clears flag and rewrites reload value
// R14: Software makes pin two an output first
// R15: Software sets start level, periods, then run
// R16: Software clears flag before enabling interrupt
// R17: Control bits 7 and 6 are reserved
// R18: Stopped timer holds count, no flag, no toggle
// R19: Clearing flag loses to same-cycle underflow
package pwm_timer_pkg;

  // Register addresses in the data space
  localparam logic [7:0] RELOAD_ADDR  = 8'haa;
  localparam logic [7:0] COUNT_ADDR   = 8'hac;
  localparam logic [7:0] CONTROL_ADDR = 8'hae;

  // Control register field positions
  localparam int PSC_LO_BIT  = 0;
  localparam int PSC_HI_BIT  = 1;
  localparam int IRQ_EN_BIT  = 2;
  localparam int PEND_BIT    = 3;
  localparam int RUN_BIT     = 4;
  localparam int TOGGLE_BIT  = 5;

  // Reset values
  localparam logic [7:0] COUNT_RESET   = 8'hff;
  localparam logic [7:0] RELOAD_RESET  = 8'h00;
  localparam logic [5:0] CONTROL_RESET = 6'h00;

  // Count value that underflows on the next tick
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // Prescaler divider width (divide by up to 8)
  localparam int PSC_WIDTH = 3;

  // Pin two position in the port registers
  localparam int PIN_TWO = 2;

endpackage : pwm_timer_pkg

/* pwm_prescaler.sv */
// Purpose: Tick enable generator dividing the clock by 1, 2, 4 or 8.
// Assumes: Runs on ref_clk; held in step while the timer is stopped.
// Notes:   Emits a one-cycle tick pulse.
`timescale 1ns/1ps
`default_nettype none

module pwm_prescaler
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Control
  input  wire logic       enable,
  input  wire logic [1:0] prescale_select,
  // Tick out
  output logic            tick
);

  logic [pwm_timer_pkg::PSC_WIDTH-1:0] div_q;
  logic [pwm_timer_pkg::PSC_WIDTH-1:0] mask;

  // Mask picks 1, 2, 4 or 8 cycles per tick [R3]
  always_comb
  begin
    case (prescale_select)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // Free counter, cleared while stopped [R18]
  always_ff @(posedge ref_clk)
  begin
    if (reset || !enable)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  assign tick = enable && ((div_q & mask) == mask); // [R3]

  // Tick spacing for divide by two
  div2_a: assert property (@(posedge ref_clk) disable iff (reset) // [R3]
    (enable && prescale_select == 2'h1 && tick) ##1
    (enable && prescale_select == 2'h1) |-> !tick)
    else $error("prescaler divide by two ticked twice");

endmodule : pwm_prescaler
`default_nettype wire

/* pwm_down_counter_timer.sv */
// Purpose: 8-bit down-counting PWM timer with auto-reload.
// Assumes: Core bus access is synchronous, one write per cycle.
// Notes:   Port pin two selects timer output when toggling is on.
`timescale 1ns/1ps
`default_nettype none

module pwm_down_counter_timer
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Core data bus
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_write,
  input  wire logic       bus_read,
  output logic      [7:0] bus_rdata,
  // Core status
  input  wire logic       global_irq_enable,
  // Port pin two register bits
  input  wire logic       port_direction_two,
  input  wire logic       port_data_two,
  // Pin and interrupt
  output logic            output_pin_two,
  output logic            output_pin_two_oe_n,
  output logic            underflow_interrupt
);

  logic [7:0] count_q;
  logic [7:0] reload_q;
  logic [1:0] prescale_select_q;
  logic       underflow_irq_enable_q;
  logic       underflow_pending_flag_q;
  logic       run_bit_q;
  logic       toggle_enable_bit_q;
  logic       pwm_output_q;
  logic       out_valid_q;
  logic       tick;
  logic       underflow;
  logic       wr_count;
  logic       wr_reload;
  logic       wr_ctrl;
  logic [7:0] ctrl_view;

  // Assertions sample on the rising clock edge and sleep during reset
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Address decode
  always_comb
  begin
    wr_count  = 1'b0;
    wr_reload = 1'b0;
    wr_ctrl   = 1'b0;
    if (bus_write && bus_addr == pwm_timer_pkg::COUNT_ADDR)
      wr_count = 1'b1;
    else if (bus_write && bus_addr == pwm_timer_pkg::RELOAD_ADDR)
      wr_reload = 1'b1;
    else if (bus_write && bus_addr == pwm_timer_pkg::CONTROL_ADDR)
      wr_ctrl = 1'b1;
  end

  // Prescaled tick source
  pwm_prescaler u_prescaler
  (
    .ref_clk         (ref_clk),
    .reset           (reset),
    .enable          (run_bit_q),
    .prescale_select (prescale_select_q),
    .tick            (tick)
  );

  // Underflow when a tick finds the count at zero
  assign underflow = tick && (count_q == pwm_timer_pkg::COUNT_BOTTOM); // [R4]

  // Count register: write, reload on underflow, or decrement
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      count_q <= pwm_timer_pkg::COUNT_RESET; // [R11]
    else if (wr_count)
      count_q <= bus_wdata;
    else if (underflow)
      count_q <= reload_q; // [R5]
    else if (tick)
      count_q <= count_q - 8'h01; // [R2] [R1] [R18]
  end

  // Auto-reload register
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reload_q <= pwm_timer_pkg::RELOAD_RESET; // [R11]
    else if (wr_reload)
      reload_q <= bus_wdata;
  end

  // Control fields; bits 7 and 6 are not stored [R17]
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      prescale_select_q      <= pwm_timer_pkg::CONTROL_RESET[1:0];
      underflow_irq_enable_q <=
        pwm_timer_pkg::CONTROL_RESET[pwm_timer_pkg::IRQ_EN_BIT];
      run_bit_q              <=
        pwm_timer_pkg::CONTROL_RESET[pwm_timer_pkg::RUN_BIT];
      toggle_enable_bit_q    <=
        pwm_timer_pkg::CONTROL_RESET[pwm_timer_pkg::TOGGLE_BIT];
    end
    else if (wr_ctrl)
    begin
      prescale_select_q      <= bus_wdata[pwm_timer_pkg::PSC_HI_BIT:
                                          pwm_timer_pkg::PSC_LO_BIT]; // [R3]
      underflow_irq_enable_q <= bus_wdata[pwm_timer_pkg::IRQ_EN_BIT];
      run_bit_q              <= bus_wdata[pwm_timer_pkg::RUN_BIT]; // [R1]
      toggle_enable_bit_q    <= bus_wdata[pwm_timer_pkg::TOGGLE_BIT];
    end
  end

  // Pending flag: underflow sets, a written zero clears, set wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      underflow_pending_flag_q <=
        pwm_timer_pkg::CONTROL_RESET[pwm_timer_pkg::PEND_BIT];
    else if (underflow)
      underflow_pending_flag_q <= 1'b1; // [R6] [R19]
    else if (wr_ctrl)
      underflow_pending_flag_q <= bus_wdata[pwm_timer_pkg::PEND_BIT]; // [R19]
  end

  // Output latch: loads from port data while toggling is off
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pwm_output_q <= 1'b0;
      out_valid_q  <= 1'b0;
    end
    else if (underflow && toggle_enable_bit_q)
    begin
      // Later toggles invert, the first inverts the start level
      pwm_output_q <= out_valid_q ? ~pwm_output_q :
                                    ~port_data_two; // [R7] [R12]
      out_valid_q  <= 1'b1;
    end
    else if (!toggle_enable_bit_q)
    begin
      pwm_output_q <= port_data_two; // Start level tracks port data
      out_valid_q  <= 1'b0;
    end
  end

  // Pin two mux with general-purpose data; direction from port
  assign output_pin_two      = toggle_enable_bit_q ?
                               (out_valid_q ? pwm_output_q : port_data_two) :
                               port_data_two; // [R8]
  assign output_pin_two_oe_n = ~port_direction_two; // [R8]

  // Interrupt: pending flag gated by local and global enables
  assign underflow_interrupt = underflow_pending_flag_q &&
                               underflow_irq_enable_q &&
                               global_irq_enable; // [R9] [R10]

  // Control register read view, reserved bits zero
  always_comb
  begin
    ctrl_view = 8'h00;
    ctrl_view[pwm_timer_pkg::PSC_HI_BIT:pwm_timer_pkg::PSC_LO_BIT] =
      prescale_select_q;
    ctrl_view[pwm_timer_pkg::IRQ_EN_BIT] = underflow_irq_enable_q;
    ctrl_view[pwm_timer_pkg::PEND_BIT]   = underflow_pending_flag_q;
    ctrl_view[pwm_timer_pkg::RUN_BIT]    = run_bit_q;
    ctrl_view[pwm_timer_pkg::TOGGLE_BIT] = toggle_enable_bit_q; // [R17]
  end

  // Registered read data
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      bus_rdata <= 8'h00;
    else if (bus_read && bus_addr == pwm_timer_pkg::COUNT_ADDR)
      bus_rdata <= count_q;
    else if (bus_read && bus_addr == pwm_timer_pkg::RELOAD_ADDR)
      bus_rdata <= reload_q;
    else if (bus_read && bus_addr == pwm_timer_pkg::CONTROL_ADDR)
      bus_rdata <= ctrl_view;
    else if (bus_read)
      bus_rdata <= 8'h00;
  end

  // Sequences for the underflow step
  sequence at_bottom_tick;
    tick && count_q == pwm_timer_pkg::COUNT_BOTTOM && !wr_count;
  endsequence

  sequence toggling_underflow;
    underflow && toggle_enable_bit_q && !wr_ctrl;
  endsequence

  sequence first_toggle;
    underflow && toggle_enable_bit_q && !out_valid_q && !wr_ctrl;
  endsequence

  // Count register and run bit behaviour
  halt_hold_a: assert property ( // [R18]
    (!run_bit_q && !wr_count) |=> $stable(count_q))
    else $error("count moved while stopped");

  reload_load_a: assert property ( // [R5]
    at_bottom_tick |=> count_q == $past(reload_q))
    else $error("count not reloaded at underflow");

  count_dec_a: assert property ( // [R2]
    (tick && count_q != pwm_timer_pkg::COUNT_BOTTOM && !wr_count)
    |=> count_q == $past(count_q) - 8'h01)
    else $error("count did not decrement");

  run_start_a: assert property ( // [R1]
    (wr_ctrl && bus_wdata[pwm_timer_pkg::RUN_BIT]) |=> run_bit_q)
    else $error("run bit not taken");

  // Pending flag behaviour
  pend_set_a: assert property ( // [R6]
    at_bottom_tick |=> underflow_pending_flag_q)
    else $error("pending flag not set");

  set_wins_a: assert property ( // [R19]
    (underflow && wr_ctrl && !bus_wdata[pwm_timer_pkg::PEND_BIT])
    |=> underflow_pending_flag_q)
    else $error("clear beat same-cycle set");

  no_stop_set_a: assert property ( // [R18]
    (!run_bit_q && !underflow_pending_flag_q && !wr_ctrl)
    |=> !underflow_pending_flag_q)
    else $error("flag set while stopped");

  // Output behaviour
  toggle_out_a: assert property ( // [R7]
    (underflow && toggle_enable_bit_q && out_valid_q && !wr_ctrl)
    |=> pwm_output_q != $past(pwm_output_q))
    else $error("output did not toggle");

  first_level_a: assert property ( // [R7]
    first_toggle |=> pwm_output_q == !$past(port_data_two))
    else $error("first toggle level wrong");

  edge_irq_a: assert property ( // [R12]
    toggling_underflow
    |=> underflow_pending_flag_q && output_pin_two == pwm_output_q)
    else $error("pin edge without pending flag");

  // Interrupt and read behaviour
  irq_gate_a: assert property ( // [R9]
    underflow_interrupt |-> (underflow_irq_enable_q && global_irq_enable))
    else $error("interrupt without enables");

  irq_edge_a: assert property ( // [R10]
    at_bottom_tick ##0 (underflow_irq_enable_q && !wr_ctrl)
    ##1 global_irq_enable |-> underflow_interrupt)
    else $error("underflow did not interrupt");

  rsvd_read_a: assert property ( // [R17]
    (bus_read && bus_addr == pwm_timer_pkg::CONTROL_ADDR)
    |=> bus_rdata[7:6] == 2'h0)
    else $error("reserved control bits read as one");

endmodule : pwm_down_counter_timer
`default_nettype wire

/* pwm_down_counter_timer_tb.sv */
// Purpose: Self-checking bench for the 8-bit PWM down-counting timer.
// Assumes: Reads return data one cycle after the read strobe.
// Notes:   Toggle periods are measured at the pin, reads go via a queue.
`timescale 1ns/1ps
`default_nettype none

module pwm_down_counter_timer_tb;
  logic       ref_clk;
  logic       reset;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_write;
  logic       bus_read;
  logic [7:0] bus_rdata;
  logic       global_irq_enable;
  logic       port_direction_two;
  logic       port_data_two;
  logic       output_pin_two;
  logic       output_pin_two_oe_n;
  logic       underflow_interrupt;
  logic [7:0] exp_q[$];
  logic       rd_q;
  int         num_errors;
  int         cmp_count;
  int         cyc;
  int         seed;
  int         n;
  logic [7:0] rl;

  pwm_down_counter_timer u_pwm_down_counter_timer
  (
    .ref_clk             (ref_clk),
    .reset               (reset),
    .bus_addr            (bus_addr),
    .bus_wdata           (bus_wdata),
    .bus_write           (bus_write),
    .bus_read            (bus_read),
    .bus_rdata           (bus_rdata),
    .global_irq_enable   (global_irq_enable),
    .port_direction_two  (port_direction_two),
    .port_data_two       (port_data_two),
    .output_pin_two      (output_pin_two),
    .output_pin_two_oe_n (output_pin_two_oe_n),
    .underflow_interrupt (underflow_interrupt)
  );

  // Clock of 20 ns period
  always #10 ref_clk = ~ref_clk;

  // Compare one value and count it
  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask : cmp

  // Compare one pin or interrupt level and count it
  task automatic cmp_bit(input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask : cmp_bit

  // Final verdict, reached from the main flow or the cycle limit
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // One register write; the strobe stays up for a following request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr  = a;
    bus_wdata = d;
    bus_read  = 1'b0;
    bus_write = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask : wr

  // One register read; the expected value is queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus_addr  = a;
    bus_write = 1'b0;
    bus_read  = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask : rd

  // Drop both strobes; no clock edge is waited for here, the caller waits
  task automatic bus_idle;
    bus_write = 1'b0;
    bus_read  = 1'b0;
  endtask : bus_idle

  // Cycles until the pin changes level
  task automatic wait_toggle(output int cnt);
    logic last;
    last = output_pin_two;
    cnt  = 0;
    while (output_pin_two === last && cnt < 2000)
    begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask : wait_toggle

  // Read data is taken one edge after the strobe was sampled
  always @(posedge ref_clk)
  begin
    if (rd_q && exp_q.size() > 0)
      cmp(exp_q.pop_front(), bus_rdata);
    rd_q <= bus_read;
  end

  // Cycle limit against a hang
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial
  begin
    ref_clk            = 1'b0;
    reset              = 1'b1;
    bus_addr           = 8'h00;
    bus_wdata          = 8'h00;
    bus_write          = 1'b0;
    bus_read           = 1'b0;
    global_irq_enable  = 1'b1;
    port_direction_two = 1'b1;
    port_data_two      = 1'b0;
    rd_q               = 1'b0;
    num_errors         = 0;
    cmp_count          = 0;
    cyc                = 0;
    seed               = 98640;
    repeat (20) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    rd(pwm_timer_pkg::RELOAD_ADDR, 8'h00);
    rd(pwm_timer_pkg::COUNT_ADDR, 8'hff);
    rd(pwm_timer_pkg::CONTROL_ADDR, 8'h00);
    rd(8'hab, 8'h00);
    wr(pwm_timer_pkg::CONTROL_ADDR, 8'hc0);
    rd(pwm_timer_pkg::CONTROL_ADDR, 8'h00);
    $display("test reset_and_reserved done");
    // Stopped timer keeps its count, pin follows port data
    wr(pwm_timer_pkg::COUNT_ADDR, 8'h40);
    bus_idle();
    repeat (30) @(posedge ref_clk);
    #1;
    rd(pwm_timer_pkg::COUNT_ADDR, 8'h40);
    rd(pwm_timer_pkg::CONTROL_ADDR, 8'h00);
    bus_idle();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      #1;
      {port_direction_two, port_data_two} = 2'($random(seed));
      #1;
      cmp_bit(port_data_two, output_pin_two);
      cmp_bit(!port_direction_two, output_pin_two_oe_n);
    end
    port_direction_two = 1'b1;
    $display("test stopped_hold done");
    // Every prescale code with a random reload value
    for (int p = 0; p < 4; p++)
    begin
      rl = 8'(($random(seed) & 7) + 2);
      wr(pwm_timer_pkg::CONTROL_ADDR, 8'h00);
      wr(pwm_timer_pkg::COUNT_ADDR, 8'h03);
      wr(pwm_timer_pkg::RELOAD_ADDR, rl);
      wr(pwm_timer_pkg::CONTROL_ADDR, 8'h34 | 8'(p));
      bus_idle();
      wait_toggle(n);
      cmp_bit(!port_data_two, output_pin_two);
      wait_toggle(n);
      cmp(8'((rl + 1) << p), 8'(n));
      cmp_bit(1'b1, underflow_interrupt);
      global_irq_enable = 1'b0;
      #1;
      cmp_bit(1'b0, underflow_interrupt);
      global_irq_enable = 1'b1;
      rd(pwm_timer_pkg::CONTROL_ADDR, 8'h3c | 8'(p));
      wr(pwm_timer_pkg::CONTROL_ADDR, 8'h34 | 8'(p));
      cmp_bit(1'b0, underflow_interrupt);
      rd(pwm_timer_pkg::CONTROL_ADDR, 8'h34 | 8'(p));
      bus_idle();
      wait_toggle(n);
      cmp_bit(1'b1, underflow_interrupt);
      wr(pwm_timer_pkg::CONTROL_ADDR, 8'h00);
      #1;
      cmp_bit(port_data_two, output_pin_two);
      $display("test prescale %0d done", p);
    end
    bus_idle();
    repeat (3) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : pwm_down_counter_timer_tb

`default_nettype wire
